// ### rtl/seq_run_pkg.sv
// Shared types and constants for the sequence run controller
package seq_run_pkg;

	// Clock and timing
	localparam int CLK_NS = 40;
	localparam int TRIG_WAVE_NS = 15_000;
	localparam int TRIG_DC_NS = 18_000;
	localparam int CONN_MIN_NS = 200_000;
	localparam int CONN_MAX_NS = 1_500_000;
	localparam int TRIG_WAVE_CYC = (TRIG_WAVE_NS + CLK_NS - 1) / CLK_NS;
	localparam int TRIG_DC_CYC = (TRIG_DC_NS + CLK_NS - 1) / CLK_NS;
	localparam int CONN_MIN_CYC = (CONN_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int CONN_MAX_CYC = CONN_MAX_NS / CLK_NS;

	// Widths and reset values
	localparam int STEP_W = 8;
	localparam int TIME_W = 32;
	localparam int RANGE_W = 4;
	localparam int DLY_W = 16;
	localparam logic [STEP_W-1:0] STEP_ZERO = 8'h00;
	localparam logic [RANGE_W-1:0] RANGE_RESET = 4'h0;

	// Synchronised pin bit positions
	localparam int PIN_START = 0;
	localparam int PIN_STOP = 1;
	localparam int PIN_HOLD = 2;
	localparam int PIN_EVENT = 3;
	localparam int PIN_TRIG = 4;
	localparam int PIN_N = 5;

	// Run states, Gray along edit, compile, armed, run, paused
	typedef enum logic [2:0] {
		ST_EDIT = 3'b000,
		ST_COMPILE = 3'b001,
		ST_ARMED = 3'b011,
		ST_RUN = 3'b010,
		ST_PAUSED = 3'b110
	} run_state_t;

	typedef enum logic [1:0] {
		TRIG_OFF = 2'b00,
		TRIG_RISE = 2'b01,
		TRIG_FALL = 2'b10
	} trig_pol_t;

	// Parameters of the step now executing
	typedef struct packed {
		logic [TIME_W-1:0] duration;
		logic [STEP_W-1:0] next_step;
		logic edge_branch_en;
		logic [STEP_W-1:0] edge_branch_dest;
		logic level_branch_en;
		logic [STEP_W-1:0] level_branch_dest;
		logic stop_phase_en;
		logic is_dc;
		logic step_code_low_bit;
	} step_info_t;

	// Soft key commands, one-cycle pulses
	typedef struct packed {
		logic compile;
		logic edit;
		logic start;
		logic stop;
		logic hold;
		logic resume;
		logic edge_branch_command;
		logic abort_now_command;
	} soft_cmd_t;

endpackage : seq_run_pkg

// ### rtl/sequence_run_controller.sv
// Sequence run state machine with external and soft key control
`timescale 1ns/1ns
`default_nettype none

// How it works
// - One step register drives both channels through identical transitions together.
// - Stop phase waits look only at the channel 1 phase reached flag.
// - Leaving step 0 at start goes to the configured first step.
// - Trigger polarity picks rise, fall or off; only channel 1 trigger used.
// - Connector start, stop, hold and branch act only with external control enabled.
// - Shared input serves start or level branch; then start is trigger only.
// - Sync output carries waveform sync or the step code low bit.
// - Output range latched at compile from peak level; frozen while running.
// - Edge branch request jumps at once to the enabled step's destination.
// - Stop while running or paused returns to step 0 and armed.
// - Compile in edit checks result; armed on success, else error flag.
// - Step cut or insert never rewrites stored destinations; none rewritten here.
// - Pause freezes step progress and output; resume continues from there.
// - Abort switches to step 0 at once, skipping stop phase and sweep.
// - Back in edit, running needs a fresh successful compile.
// - Start pin falling edge starts only when armed.
// - Stop pin falling edge while running or paused ends the sequence.
// - Hold pin fall pauses when running; rise resumes when paused.
// - Event pin falling edge causes edge branch when the step enables it.
// - Low level branch input moves to level branch destination when enabled.
// - Connector start, stop and event act after a fixed connector latency.
// - Trigger starts only; delayed 15 us for waveforms, 18 us for DC.
// - Level branch input sampled only after step time, pause excluded.
module sequence_run_controller #(
	parameter int CONN_DELAY = seq_run_pkg::CONN_MIN_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Soft key commands and compiler handshake
	input wire seq_run_pkg::soft_cmd_t soft_cmd,
	input wire logic compile_done,
	input wire logic compile_ok,
	input wire logic [seq_run_pkg::RANGE_W-1:0] peak_range,
	// Common sequence settings
	input wire logic [seq_run_pkg::STEP_W-1:0] start_step,
	input wire seq_run_pkg::trig_pol_t trig_polarity,
	input wire logic external_control_enable,
	input wire logic shared_input_assignment,
	input wire logic sync_output_select,
	// Connector pins, active low, and channel 1 trigger
	input wire logic ext_start_n,
	input wire logic ext_stop_n,
	input wire logic ext_hold_n,
	input wire logic ext_event_n,
	input wire logic trig_ch1,
	// Step engine
	input wire seq_run_pkg::step_info_t step_info,
	input wire logic ch1_phase_reached,
	input wire logic sweep_busy,
	input wire logic wave_sync,
	// Status and control outputs
	output seq_run_pkg::run_state_t run_state,
	output logic [seq_run_pkg::STEP_W-1:0] step_index,
	output logic step_load,
	output logic compile_request,
	output logic compile_error,
	output logic [seq_run_pkg::RANGE_W-1:0] output_range,
	output logic hold_output,
	output logic sync_out
);

	logic [seq_run_pkg::PIN_N-1:0] pin_meta;
	logic [seq_run_pkg::PIN_N-1:0] pin_sync;
	logic [seq_run_pkg::PIN_N-1:0] pin_last;
	logic [seq_run_pkg::PIN_N-1:0] pin_fall;
	logic [seq_run_pkg::PIN_N-1:0] pin_rise;
	localparam int DLY_W = seq_run_pkg::DLY_W;
	logic running, trig_edge, conn_start_pin, conn_fire;
	logic [seq_run_pkg::DLY_W-1:0] conn_cnt;
	logic conn_start_pend, conn_stop_pend, conn_event_pend;
	logic [seq_run_pkg::DLY_W-1:0] trig_cnt;
	logic trig_pend, trig_fire, time_done, stop_pend, start_wait;
	logic [seq_run_pkg::TIME_W-1:0] elapsed;
	logic do_start, do_stop, do_abort, do_hold, do_resume;
	logic do_edge_branch, do_level_branch, step_end, phase_ok, compiled;
	seq_run_pkg::run_state_t next_state;
	logic [seq_run_pkg::STEP_W-1:0] next_step;
	logic next_load;

	genvar gi;
	generate
		for (gi = 0; gi < seq_run_pkg::PIN_N; gi++) begin : g_sync
			always_ff @(posedge clk_sys or posedge rst) begin
				// Rest levels: connector high, trigger low
				if (rst) begin
					pin_meta[gi] <= gi != seq_run_pkg::PIN_TRIG;
					pin_sync[gi] <= gi != seq_run_pkg::PIN_TRIG;
					pin_last[gi] <= gi != seq_run_pkg::PIN_TRIG;
				end else begin
					pin_meta[gi] <= gi == seq_run_pkg::PIN_START ? ext_start_n :
						gi == seq_run_pkg::PIN_STOP ? ext_stop_n :
						gi == seq_run_pkg::PIN_HOLD ? ext_hold_n :
						gi == seq_run_pkg::PIN_EVENT ? ext_event_n : trig_ch1;
					pin_sync[gi] <= pin_meta[gi];
					pin_last[gi] <= pin_sync[gi];
				end
			end
			assign pin_fall[gi] = pin_last[gi] & ~pin_sync[gi];
			assign pin_rise[gi] = ~pin_last[gi] & pin_sync[gi];
		end
	endgenerate

	assign running = run_state == seq_run_pkg::ST_RUN ||
		run_state == seq_run_pkg::ST_PAUSED;

	assign trig_edge = trig_polarity == seq_run_pkg::TRIG_RISE ?
		pin_rise[seq_run_pkg::PIN_TRIG] :
		trig_polarity == seq_run_pkg::TRIG_FALL ?
		pin_fall[seq_run_pkg::PIN_TRIG] : 1'b0;

	// shared pin is start only when assigned so
	assign conn_start_pin = ~shared_input_assignment &
		pin_fall[seq_run_pkg::PIN_START];

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			conn_cnt <= '0;
			conn_start_pend <= 1'b0;
			conn_stop_pend <= 1'b0;
			conn_event_pend <= 1'b0;
		end else if (!external_control_enable) begin
			conn_cnt <= '0;
			conn_start_pend <= 1'b0;
			conn_stop_pend <= 1'b0;
			conn_event_pend <= 1'b0;
		end else begin
			conn_start_pend <= conn_start_pin ||
				(conn_start_pend && !conn_fire);
			conn_stop_pend <= pin_fall[seq_run_pkg::PIN_STOP] ||
				(conn_stop_pend && !conn_fire);
			conn_event_pend <= pin_fall[seq_run_pkg::PIN_EVENT] ||
				(conn_event_pend && !conn_fire);
			if (conn_cnt > DLY_W'(1))
				conn_cnt <= conn_cnt - 1'b1;
			else if (conn_start_pin || pin_fall[seq_run_pkg::PIN_STOP] ||
					pin_fall[seq_run_pkg::PIN_EVENT])
				conn_cnt <= DLY_W'(CONN_DELAY);
			else
				conn_cnt <= '0;
		end
	end
	assign conn_fire = conn_cnt == DLY_W'(1);

	// trigger start latency by waveform kind
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			trig_cnt <= '0;
			trig_pend <= 1'b0;
		end else if (trig_pend) begin
			trig_cnt <= trig_cnt - 1'b1;
			if (trig_fire || run_state != seq_run_pkg::ST_ARMED)
				trig_pend <= 1'b0;
		end else if (trig_edge && run_state == seq_run_pkg::ST_ARMED) begin
			trig_pend <= 1'b1;
			trig_cnt <= step_info.is_dc ?
				DLY_W'(seq_run_pkg::TRIG_DC_CYC) :
				DLY_W'(seq_run_pkg::TRIG_WAVE_CYC);
		end
	end
	assign trig_fire = trig_pend && trig_cnt == DLY_W'(1);

	assign do_start = run_state == seq_run_pkg::ST_ARMED &&
		(soft_cmd.start || trig_fire || (conn_fire && conn_start_pend));
	assign do_stop = running && (soft_cmd.stop || (conn_fire && conn_stop_pend));
	assign do_abort = running && soft_cmd.abort_now_command;
	// hold pin edges, gated by enable
	assign do_hold = run_state == seq_run_pkg::ST_RUN && (soft_cmd.hold ||
		(external_control_enable && pin_fall[seq_run_pkg::PIN_HOLD]));
	assign do_resume = run_state == seq_run_pkg::ST_PAUSED && (soft_cmd.resume ||
		(external_control_enable && pin_rise[seq_run_pkg::PIN_HOLD]));
	// event pin or soft key, step must enable it
	assign do_edge_branch = running && !start_wait &&
		step_info.edge_branch_en && (soft_cmd.edge_branch_command ||
		(conn_fire && conn_event_pend));

	// step time counts only while running
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			elapsed <= '0;
		else if (next_load || !running)
			elapsed <= '0;
		else if (run_state == seq_run_pkg::ST_RUN && !time_done)
			elapsed <= elapsed + 1'b1;
	end
	assign time_done = elapsed >= step_info.duration;

	// low level branch, enable and assignment gated
	assign do_level_branch = running && !start_wait && time_done &&
		external_control_enable && shared_input_assignment &&
		step_info.level_branch_en && !pin_sync[seq_run_pkg::PIN_START];

	// stop phase judged on channel 1 only
	assign phase_ok = !step_info.stop_phase_en || ch1_phase_reached;
	assign step_end = run_state == seq_run_pkg::ST_RUN && time_done &&
		phase_ok && !sweep_busy;

	// Stop request waits for stop phase and sweep when running; when paused it ends at once
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			stop_pend <= 1'b0;
		else if (!running)
			stop_pend <= 1'b0;
		else if (do_stop)
			stop_pend <= 1'b1;
	end

	// compiled image valid only until edit
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			compiled <= 1'b0;
			compile_error <= 1'b0;
			compile_request <= 1'b0;
			output_range <= seq_run_pkg::RANGE_RESET;
		end else begin
			compile_request <= run_state == seq_run_pkg::ST_EDIT &&
				soft_cmd.compile;
			if (run_state == seq_run_pkg::ST_EDIT)
				compiled <= 1'b0;
			if (run_state == seq_run_pkg::ST_COMPILE && compile_done) begin
				compiled <= compile_ok;
				compile_error <= !compile_ok;
				if (compile_ok)
					output_range <= peak_range;
			end else if (run_state == seq_run_pkg::ST_EDIT && soft_cmd.compile) begin
				compile_error <= 1'b0;
			end
		end
	end

	// next state and step; destinations only read
	always_comb begin
		next_state = run_state;
		next_step = step_index;
		next_load = 1'b0;
		case (run_state)
			seq_run_pkg::ST_EDIT: begin
				if (soft_cmd.compile)
					next_state = seq_run_pkg::ST_COMPILE;
			end
			seq_run_pkg::ST_COMPILE: begin
				if (compile_done)
					next_state = compile_ok ? seq_run_pkg::ST_ARMED :
						seq_run_pkg::ST_EDIT;
			end
			seq_run_pkg::ST_ARMED: begin
				if (soft_cmd.edit)
					next_state = seq_run_pkg::ST_EDIT;
				else if (do_start && compiled)
					next_state = seq_run_pkg::ST_RUN;
			end
			seq_run_pkg::ST_RUN, seq_run_pkg::ST_PAUSED: begin
				if (do_abort || (stop_pend && (step_end ||
						run_state == seq_run_pkg::ST_PAUSED))) begin
					next_state = seq_run_pkg::ST_ARMED;
					next_step = seq_run_pkg::STEP_ZERO;
					next_load = 1'b1;
				end else if (do_edge_branch) begin
					next_step = step_info.edge_branch_dest;
					next_load = 1'b1;
				end else if (do_level_branch) begin
					next_step = step_info.level_branch_dest;
					next_load = 1'b1;
				end else if (start_wait && run_state == seq_run_pkg::ST_RUN &&
						phase_ok) begin
					next_step = start_step;
					next_load = 1'b1;
				end else if (!start_wait && step_end) begin
					next_step = step_info.next_step;
					next_load = 1'b1;
					if (step_info.next_step == seq_run_pkg::STEP_ZERO)
						next_state = seq_run_pkg::ST_ARMED;
				end
				if (next_state == run_state) begin
					if (do_hold)
						next_state = seq_run_pkg::ST_PAUSED;
					else if (do_resume)
						next_state = seq_run_pkg::ST_RUN;
				end
			end
			default: next_state = seq_run_pkg::ST_EDIT;
		endcase
	end

	// one step register for both channels
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			run_state <= seq_run_pkg::ST_EDIT;
			step_index <= seq_run_pkg::STEP_ZERO;
			step_load <= 1'b0;
			start_wait <= 1'b0;
		end else begin
			run_state <= next_state;
			step_index <= next_step;
			step_load <= next_load;
			if (run_state == seq_run_pkg::ST_ARMED &&
					next_state == seq_run_pkg::ST_RUN)
				start_wait <= 1'b1;
			else if (next_load)
				start_wait <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			hold_output <= 1'b0;
		else
			hold_output <= next_state == seq_run_pkg::ST_PAUSED;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			sync_out <= 1'b0;
		else
			sync_out <= sync_output_select ? step_info.step_code_low_bit :
				wave_sync;
	end

endmodule : sequence_run_controller

`default_nettype wire

// ### tb/ext_equipment.sv
// Model of the external equipment on the connector and trigger input
`timescale 1ns/1ns
`default_nettype none
module ext_equipment (
	// Clock
	input wire logic clk_sys,
	// Start, stop, hold, event (active low) and trigger
	output var logic [4:0] pins
);
	// Connector pins rest high, trigger rests low
	initial pins = 5'h0f;
	task automatic drive(input int idx, input logic lvl);
		@(negedge clk_sys);
		pins[idx] = lvl;
		repeat (4) @(negedge clk_sys);
	endtask : drive
endmodule : ext_equipment
`default_nettype wire

// ### tb/sequence_run_controller_properties.sv
// Port-level assertions for the sequence run controller
`timescale 1ns/1ns
`default_nettype none
module sequence_run_controller_properties #(
	parameter int CONN_DELAY = seq_run_pkg::CONN_MIN_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Watched inputs
	input wire seq_run_pkg::soft_cmd_t soft_cmd,
	input wire logic compile_done,
	input wire logic compile_ok,
	input wire logic [3:0] peak_range,
	input wire logic [7:0] start_step,
	input wire logic sync_output_select,
	input wire seq_run_pkg::step_info_t step_info,
	input wire logic wave_sync,
	// Watched outputs
	input wire seq_run_pkg::run_state_t run_state,
	input wire logic [7:0] step_index,
	input wire logic step_load,
	input wire logic compile_request,
	input wire logic compile_error,
	input wire logic [3:0] output_range,
	input wire logic hold_output,
	input wire logic sync_out
);
	logic active;
	assign active = run_state == seq_run_pkg::ST_RUN ||
		run_state == seq_run_pkg::ST_PAUSED;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	sequence s_start;
		soft_cmd.start && run_state == seq_run_pkg::ST_ARMED &&
		!soft_cmd.stop && !soft_cmd.abort_now_command &&
		!step_info.stop_phase_en;
	endsequence
	sequence s_done;
		compile_done && run_state == seq_run_pkg::ST_COMPILE;
	endsequence
	AST_ABORT_HOME: assert property (
		soft_cmd.abort_now_command && active |=>
		run_state == seq_run_pkg::ST_ARMED && step_index == 8'h00)
		else $error("abort did not return to step 0");
	AST_START_FIRST: assert property (
		s_start |=> run_state == seq_run_pkg::ST_RUN ##[0:4]
		step_index == start_step)
		else $error("start did not reach first step");
	AST_EDGE_JUMP: assert property (
		soft_cmd.edge_branch_command && run_state == seq_run_pkg::ST_RUN &&
		step_info.edge_branch_en && step_index != 8'h00 &&
		!soft_cmd.stop && !soft_cmd.abort_now_command |=>
		step_index == $past(step_info.edge_branch_dest))
		else $error("edge branch missed destination");
	AST_EDIT_NO_START: assert property (
		soft_cmd.start && !soft_cmd.compile &&
		run_state == seq_run_pkg::ST_EDIT |=>
		run_state == seq_run_pkg::ST_EDIT)
		else $error("start accepted in edit");
	AST_COMPILE_FAIL: assert property (
		s_done ##0 !compile_ok |=>
		run_state == seq_run_pkg::ST_EDIT && compile_error)
		else $error("failed compile not reported");
	AST_COMPILE_OK: assert property (
		s_done ##0 compile_ok |=> run_state == seq_run_pkg::ST_ARMED &&
		output_range == $past(peak_range))
		else $error("compile did not arm with range");
	AST_RANGE_FROZEN: assert property (
		active |=> $stable(output_range))
		else $error("range changed while running");
	AST_HOLD_LEVEL: assert property (
		active && $stable(run_state) |->
		hold_output == (run_state == seq_run_pkg::ST_PAUSED))
		else $error("hold output disagrees with state");
	AST_SYNC_ROUTE: assert property (
		!$past(rst) |-> sync_out == $past(sync_output_select ?
		step_info.step_code_low_bit : wave_sync))
		else $error("sync output source wrong");
	AST_STEP_LOAD: assert property (
		!$stable(step_index) |-> step_load)
		else $error("step change without load pulse");
	AST_COMPILE_REQ: assert property (
		soft_cmd.compile && run_state == seq_run_pkg::ST_EDIT |=>
		compile_request)
		else $error("compile key gave no request");
endmodule : sequence_run_controller_properties
bind sequence_run_controller sequence_run_controller_properties #(
	.CONN_DELAY(CONN_DELAY)
) props_inst (
	.clk_sys(clk_sys), .rst(rst), .soft_cmd(soft_cmd),
	.compile_done(compile_done), .compile_ok(compile_ok),
	.peak_range(peak_range), .start_step(start_step),
	.sync_output_select(sync_output_select), .step_info(step_info),
	.wave_sync(wave_sync), .run_state(run_state), .step_index(step_index),
	.step_load(step_load), .compile_request(compile_request),
	.compile_error(compile_error), .output_range(output_range),
	.hold_output(hold_output), .sync_out(sync_out)
);
`default_nettype wire

// ### tb/test_sequence_run_controller.sv
// Self-checking testbench for the sequence run controller
`timescale 1ns/1ns
`default_nettype none
module test_sequence_run_controller;
	localparam int ST = 0;
	localparam int SP = 1;
	localparam int CE = 2;
	localparam int RG = 3;
	localparam int SO = 4;
	logic clk_sys;
	logic rst;
	seq_run_pkg::soft_cmd_t soft_cmd;
	logic compile_done;
	logic compile_ok;
	logic [3:0] peak_range;
	seq_run_pkg::trig_pol_t trig_polarity;
	logic external_control_enable;
	logic shared_input_assignment;
	logic sync_output_select;
	seq_run_pkg::step_info_t step_info;
	logic [4:0] pins;
	seq_run_pkg::run_state_t run_state;
	logic [7:0] step_index;
	logic compile_error;
	logic [3:0] output_range;
	logic sync_out;
	logic ch1_phase_reached;
	logic sweep_busy;
	int num_errors;
	int checks_done;
	sequence_run_controller #(.CONN_DELAY(4)) sequence_run_controller_inst (
		.clk_sys(clk_sys), .rst(rst), .soft_cmd(soft_cmd),
		.compile_done(compile_done), .compile_ok(compile_ok),
		.peak_range(peak_range), .start_step(8'h03),
		.trig_polarity(trig_polarity),
		.external_control_enable(external_control_enable),
		.shared_input_assignment(shared_input_assignment),
		.sync_output_select(sync_output_select),
		.ext_start_n(pins[0]), .ext_stop_n(pins[1]), .ext_hold_n(pins[2]),
		.ext_event_n(pins[3]), .trig_ch1(pins[4]), .step_info(step_info),
		.ch1_phase_reached(ch1_phase_reached), .sweep_busy(sweep_busy),
		.wave_sync(1'b0),
		.run_state(run_state), .step_index(step_index), .step_load(),
		.compile_request(), .compile_error(compile_error),
		.output_range(output_range), .hold_output(), .sync_out(sync_out)
	);
	ext_equipment ext_equipment_inst (.clk_sys(clk_sys), .pins(pins));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	function automatic logic [7:0] out(int w);
		case (w)
			ST: return {5'h00, run_state};
			SP: return step_index;
			CE: return {7'h00, compile_error};
			RG: return {4'h0, output_range};
			default: return {7'h00, sync_out};
		endcase
	endfunction : out
	task automatic expect_out(int w, logic [7:0] exp, int n);
		int i;
		i = 0;
		while (out(w) !== exp && i < n) begin
			@(negedge clk_sys);
			i++;
		end
		checks_done++;
		if (out(w) !== exp) begin
			num_errors++;
			$display("BAD %0t output %0d got %h", $time, w, out(w));
		end
	endtask : expect_out
	// Bit index into the soft key struct, abort is bit 0
	task automatic key(int b);
		@(negedge clk_sys);
		soft_cmd = 8'h01 << b;
		@(negedge clk_sys);
		soft_cmd = '0;
	endtask : key
	task automatic pin(int idx, logic lvl);
		ext_equipment_inst.drive(idx, lvl);
	endtask : pin
	task automatic run_compile(logic ok);
		key(7);
		expect_out(ST, seq_run_pkg::ST_COMPILE, 3);
		compile_ok = ok;
		compile_done = 1'b1;
		@(negedge clk_sys);
		compile_done = 1'b0;
	endtask : run_compile
	task automatic summarize;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		$display("BAD %0t timeout", $time);
		summarize();
	end
	initial begin
		rst = 1'b1;
		soft_cmd = '0;
		compile_done = 1'b0;
		compile_ok = 1'b0;
		peak_range = 4'h0;
		trig_polarity = seq_run_pkg::TRIG_OFF;
		external_control_enable = 1'b0;
		shared_input_assignment = 1'b0;
		sync_output_select = 1'b0;
		ch1_phase_reached = 1'b1;
		sweep_busy = 1'b0;
		step_info = '{32'h0000_0040, 8'h05, 1'b1, 8'h07, 1'b0, 8'h09,
			1'b0, 1'b0, 1'b1};
		num_errors = 0;
		checks_done = 0;
		repeat (10) @(negedge clk_sys);
		rst = 1'b0;
		expect_out(SP, 8'h00, 0);
		key(5);
		expect_out(ST, seq_run_pkg::ST_EDIT, 2);
		run_compile(1'b0);
		expect_out(CE, 8'h01, 3);
		peak_range = 4'h9;
		run_compile(1'b1);
		expect_out(ST, seq_run_pkg::ST_ARMED, 3);
		expect_out(RG, 8'h09, 0);
		key(5);
		expect_out(ST, seq_run_pkg::ST_RUN, 3);
		expect_out(SP, 8'h03, 8);
		key(1);
		expect_out(SP, 8'h07, 3);
		key(3);
		expect_out(ST, seq_run_pkg::ST_PAUSED, 3);
		repeat (100) @(negedge clk_sys);
		expect_out(SP, 8'h07, 0);
		key(2);
		expect_out(ST, seq_run_pkg::ST_RUN, 3);
		expect_out(SP, 8'h05, 80);
		key(0);
		expect_out(ST, seq_run_pkg::ST_ARMED, 2);
		expect_out(SP, 8'h00, 0);
		pin(0, 1'b0);
		pin(0, 1'b1);
		repeat (20) @(negedge clk_sys);
		expect_out(ST, seq_run_pkg::ST_ARMED, 0);
		external_control_enable = 1'b1;
		pin(0, 1'b0);
		expect_out(ST, seq_run_pkg::ST_RUN, 20);
		pin(0, 1'b1);
		pin(2, 1'b0);
		expect_out(ST, seq_run_pkg::ST_PAUSED, 10);
		pin(2, 1'b1);
		expect_out(ST, seq_run_pkg::ST_RUN, 10);
		pin(1, 1'b0);
		expect_out(ST, seq_run_pkg::ST_ARMED, 150);
		expect_out(SP, 8'h00, 0);
		pin(1, 1'b1);
		shared_input_assignment = 1'b1;
		pin(0, 1'b0);
		pin(0, 1'b1);
		repeat (20) @(negedge clk_sys);
		expect_out(ST, seq_run_pkg::ST_ARMED, 0);
		pin(4, 1'b1);
		pin(4, 1'b0);
		repeat (460) @(negedge clk_sys);
		expect_out(ST, seq_run_pkg::ST_ARMED, 0);
		trig_polarity = seq_run_pkg::TRIG_RISE;
		pin(4, 1'b1);
		repeat (350) @(negedge clk_sys);
		expect_out(ST, seq_run_pkg::ST_ARMED, 0);
		expect_out(ST, seq_run_pkg::ST_RUN, 40);
		key(0);
		expect_out(ST, seq_run_pkg::ST_ARMED, 2);
		trig_polarity = seq_run_pkg::TRIG_FALL;
		pin(4, 1'b0);
		expect_out(ST, seq_run_pkg::ST_RUN, 460);
		step_info.level_branch_en = 1'b1;
		pin(0, 1'b0);
		expect_out(SP, 8'h09, 150);
		pin(0, 1'b1);
		step_info.level_branch_en = 1'b0;
		pin(3, 1'b0);
		expect_out(SP, 8'h07, 20);
		pin(3, 1'b1);
		sync_output_select = 1'b1;
		expect_out(SO, 8'h01, 2);
		sync_output_select = 1'b0;
		expect_out(SO, 8'h00, 2);
		step_info.stop_phase_en = 1'b1;
		ch1_phase_reached = 1'b0;
		key(4);
		repeat (100) @(negedge clk_sys);
		expect_out(ST, seq_run_pkg::ST_RUN, 0);
		ch1_phase_reached = 1'b1;
		expect_out(ST, seq_run_pkg::ST_ARMED, 3);
		expect_out(SP, 8'h00, 0);
		key(5);
		expect_out(SP, 8'h03, 8);
		sweep_busy = 1'b1;
		key(4);
		repeat (100) @(negedge clk_sys);
		expect_out(ST, seq_run_pkg::ST_RUN, 0);
		key(0);
		expect_out(ST, seq_run_pkg::ST_ARMED, 2);
		key(6);
		expect_out(ST, seq_run_pkg::ST_EDIT, 3);
		key(5);
		repeat (3) @(negedge clk_sys);
		expect_out(ST, seq_run_pkg::ST_EDIT, 0);
		summarize();
	end
endmodule : test_sequence_run_controller
`default_nettype wire
